/* hdl/liu_event_defs.svh */
// Constants for the per-channel event flag and error counter registers.
// Assumes it is included by name, once per compile unit.
`ifndef LIU_EVENT_DEFS_SVH
`define LIU_EVENT_DEFS_SVH

`define EVT_FLAGS_CH1_OFS    8'h19
`define EVT_CNT_LOW_CH1_OFS  8'h1A
`define EVT_CNT_HIGH_CH1_OFS 8'h1B
`define EVT_FLAGS_CH2_OFS    8'h39
`define EVT_CNT_LOW_CH2_OFS  8'h3A
`define EVT_CNT_HIGH_CH2_OFS 8'h3B

`define BIT_PULSE_AMP_OVER   7
`define BIT_JITTER_OVER      6
`define BIT_JITTER_UNDER     5
`define BIT_PATTERN_ERROR    4
`define BIT_MANY_ZEROS       3
`define BIT_CODE_VIOLATION   2
`define BIT_SECOND_TIMER     1
`define BIT_COUNTER_WRAP     0

`define FLAGS_RESET          8'h00
`define COUNT_RESET          16'h0000

`endif

/* hdl/liu_event_pkg.sv */
// Types shared by the event flag and counter register block.
// Assumes nothing beyond a SystemVerilog compiler.
package liu_event_pkg;

    // Control interface styles picked by the interface-select straps.
    typedef enum logic [1:0] {
        IF_HARDWARE  = 2'h0,
        IF_SERIAL    = 2'h1,
        IF_PARALLEL1 = 2'h2,
        IF_PARALLEL2 = 2'h3
    } ctrl_if_t;

endpackage : liu_event_pkg

/* hdl/liu_event_status_counter_regs.sv */
// Per-channel event flags that clear on read, the 16-bit error counter
// bytes, and the decode of the interface and termination straps.
// Assumes event inputs are one-cycle pulses synchronous to ref_clk and that
// the host bus logic presents one read strobe per register read.
//
// How it works
// - Reading flag register returns then clears flags.
// - Bit 7 latches pulse amplitude overflow.
// - Bit 6 latches jitter buffer overflow.
// - Bit 5 latches jitter buffer underflow.
// - Bit 4 latches pattern checker bit error.
// - Bit 3 latches many-zeros detection.
// - Bit 2 latches line code violation.
// - Bit 1 latches one-second timer expiry.
// - Bit 0 latches error counter overflow.
// - Low byte register shows counter bits 7-0.
// - High byte shows bits 15-8; reset zero.
// - Interface straps decode to four control styles.
// - Each channel has its own termination strap.
// - Strap low means internal matching both paths.
// - Strap high: external, except T1/J1 transmitter.
`include "liu_event_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module liu_event_status_counter_regs
    import liu_event_pkg::*;
#(
    parameter int CHANNELS = 2,
    parameter int CNT_W    = 16
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    input  wire logic                  reg_rd,
    input  wire logic [7:0]            reg_addr,
    output var  logic [7:0]            reg_rdata,
    input  wire logic [CHANNELS*8-1:0] event_pulse,
    input  wire logic [CHANNELS-1:0]   error_tick,
    input  wire logic [CHANNELS-1:0]   counter_clear,
    output var  logic [CHANNELS-1:0]   event_irq,
    input  wire logic [1:0]            interface_select_strap,
    input  wire logic [CHANNELS-1:0]   termination_select_strap,
    input  wire logic [CHANNELS-1:0]   channel_e1_mode,
    output var  logic [1:0]            ctrl_if_mode,
    output var  logic [CHANNELS-1:0]   rx_external_match,
    output var  logic [CHANNELS-1:0]   tx_external_match
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode helpers.

    // Offset of a channel's register: channel 2 sits 0x20 above channel 1.
    function automatic logic [7:0] chan_ofs(input logic [7:0] base,
                                            input int ch);
        chan_ofs = base + (ch[0] ? 8'h20 : 8'h00);
    endfunction : chan_ofs

    ////////////////////////////////////////////////////////////////////////
    // Per-channel state.

    logic [7:0]       flags     [CHANNELS];
    logic [CNT_W-1:0] err_count [CHANNELS];
    logic [CHANNELS-1:0] flag_read;
    logic [CHANNELS-1:0] wrap;

    // A read strobe at a channel's flag offset is the clearing read.
    always_comb begin
        for (int ch = 0; ch < CHANNELS; ch++) begin
            flag_read[ch] = reg_rd &&
                (reg_addr == chan_ofs(`EVT_FLAGS_CH1_OFS, ch));
            wrap[ch] = error_tick[ch] && (&err_count[ch]);
        end
    end

    // Error counter counts up and wraps; the wrap feeds bit 0.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int ch = 0; ch < CHANNELS; ch++)
                err_count[ch] <= `COUNT_RESET;
        end else begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                if (counter_clear[ch])
                    err_count[ch] <= `COUNT_RESET;
                else if (error_tick[ch])
                    err_count[ch] <= err_count[ch] + 1'b1;
            end
        end
    end

    // Flags: a new event wins over the clear so no event is lost; the
    // read returns the value sampled before the clear takes effect.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int ch = 0; ch < CHANNELS; ch++)
                flags[ch] <= `FLAGS_RESET;
        end else begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                logic [7:0] set_v;
                set_v = event_pulse[ch*8 +: 8];
                set_v[`BIT_COUNTER_WRAP] = set_v[`BIT_COUNTER_WRAP] |
                                           wrap[ch];
                // Bits 7..1 each latch their own source event.
                flags[ch] <= (flag_read[ch] ? 8'h00 : flags[ch])
                             | set_v;
            end
        end
    end

    // Interrupt request follows any set flag and drops with the read.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            event_irq <= '0;
        else
            for (int ch = 0; ch < CHANNELS; ch++)
                event_irq[ch] <= (flag_read[ch] ? 1'b0 : |flags[ch])
                    | (|event_pulse[ch*8 +: 8]) | wrap[ch];
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, registered one cycle after the read strobe.

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= 8'h00; // Unmapped offsets read zero.
            for (int ch = 0; ch < CHANNELS; ch++) begin
                if (reg_addr == chan_ofs(`EVT_FLAGS_CH1_OFS, ch))
                    reg_rdata <= flags[ch];
                if (reg_addr == chan_ofs(`EVT_CNT_LOW_CH1_OFS, ch))
                    reg_rdata <= err_count[ch][7:0];
                if (reg_addr == chan_ofs(`EVT_CNT_HIGH_CH1_OFS, ch))
                    reg_rdata <= err_count[ch][CNT_W-1 -: 8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strap decode, caught continuously by the clock after reset release.

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            ctrl_if_mode <= IF_HARDWARE;
        else
            ctrl_if_mode <= ctrl_if_t'(interface_select_strap);
    end

    // Termination is per channel; T1/J1 transmitters stay internal.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_external_match <= '0;
            tx_external_match <= '0;
        end else begin
            rx_external_match <= termination_select_strap;
            tx_external_match <= termination_select_strap
                                 & channel_e1_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence clearing_read(int ch);
        flag_read[ch] && !(|event_pulse[ch*8 +: 8]) && !wrap[ch];
    endsequence

    chk_read_clears_flags: assert property (@(posedge ref_clk)
        disable iff (!rst_b) clearing_read(0) |=> flags[0] == 8'h00)
        else $error("flags not cleared by read");
    chk_irq_withdrawn: assert property (@(posedge ref_clk)
        disable iff (!rst_b) clearing_read(0) |=> !event_irq[0])
        else $error("irq not withdrawn by read");
    chk_flag_sticky: assert property (@(posedge ref_clk)
        disable iff (!rst_b) flags[0][7] && !flag_read[0]
        |=> flags[0][7])
        else $error("flag dropped without read");
    chk_event_sets: assert property (@(posedge ref_clk)
        disable iff (!rst_b) event_pulse[6] |=> flags[0][6])
        else $error("event did not set flag");
    chk_set_beats_clear: assert property (@(posedge ref_clk)
        disable iff (!rst_b) flag_read[1] && event_pulse[12]
        |=> flags[1][4])
        else $error("event lost on clearing read");
    chk_wrap_sets_bit0: assert property (@(posedge ref_clk)
        disable iff (!rst_b) error_tick[0] && !counter_clear[0]
        && err_count[0] == 16'hFFFF
        |=> flags[0][0] && err_count[0] == 16'h0000)
        else $error("wrap did not set bit 0");
    chk_low_byte_read: assert property (@(posedge ref_clk)
        disable iff (!rst_b) reg_rd && reg_addr == 8'h1A
        |=> reg_rdata == $past(err_count[0][7:0]))
        else $error("low byte mismatch");
    chk_high_byte_read: assert property (@(posedge ref_clk)
        disable iff (!rst_b) reg_rd && reg_addr == 8'h3B
        |=> reg_rdata == $past(err_count[1][15:8]))
        else $error("high byte mismatch");
    chk_mode_decode: assert property (@(posedge ref_clk)
        disable iff (!rst_b) 1'b1
        |=> ctrl_if_mode == $past(interface_select_strap))
        else $error("interface strap decode wrong");
    chk_t1_tx_internal: assert property (@(posedge ref_clk)
        disable iff (!rst_b) !channel_e1_mode[0] |=> !tx_external_match[0])
        else $error("T1 transmitter external");

endmodule : liu_event_status_counter_regs

`default_nettype wire

/* tb/host_bus_model.sv */
// Host model that issues single reads on the register strobe bus.
// Assumes each read is started just after a rising edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
    input  wire logic       ref_clk,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_addr,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_rd   = 1'b0;
        reg_addr = 8'h00;
    end

    // Hold strobe and address through the taking edge, then idle a cycle.
    // The address is inverted on release so a stale value never matches.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(posedge ref_clk);
        #1;
        d        = reg_rdata;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        @(posedge ref_clk);
        #1;
    endtask : rd
endmodule : host_bus_model
`default_nettype wire

/* tb/tb_liu_event_status_counter_regs.sv */
// Bench for the event flag, error counter and strap decode block.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_liu_event_status_counter_regs;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        reg_rd;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_rdata;
    logic [15:0] event_pulse = '0;
    logic [1:0]  error_tick = '0;
    logic [1:0]  counter_clear = '0;
    logic [1:0]  event_irq;
    logic [1:0]  iface = '0;
    logic [1:0]  term = '0;
    logic [1:0]  e1 = '0;
    logic [1:0]  mode;
    logic [1:0]  rxm;
    logic [1:0]  txm;
    logic [7:0]  d;
    logic [7:0]  ofs [8] = '{8'h19, 8'h1A, 8'h1B, 8'h39, 8'h3A, 8'h3B,
                             8'h00, 8'hFF};
    int          cycles = 0;
    int          fail_count = 0;
    int          cmp_count = 0;

    always #12.5 ref_clk = ~ref_clk;

    liu_event_status_counter_regs i_liu_event_status_counter_regs (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_rdata(reg_rdata),
        .event_pulse(event_pulse), .error_tick(error_tick),
        .counter_clear(counter_clear), .event_irq(event_irq),
        .interface_select_strap(iface), .termination_select_strap(term),
        .channel_e1_mode(e1), .ctrl_if_mode(mode),
        .rx_external_match(rxm), .tx_external_match(txm));

    host_bus_model i_host_bus_model (
        .ref_clk(ref_clk), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_rdata(reg_rdata));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // A hung design must still reach the closing report.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence; inputs change one nanosecond after each rising edge.
    initial begin
        repeat (16) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        foreach (ofs[i]) begin
            i_host_bus_model.rd(ofs[i], d);
            chk("reset", 8'h00, d);
        end
        // Every flag of both channels: set, read once, then gone.
        for (int c = 0; c < 2; c++) begin
            for (int b = 0; b < 8; b++) begin
                event_pulse[c*8+b] = 1'b1;
                @(posedge ref_clk);
                #1 event_pulse = '0;
                chk("irq", 8'(1 << c), {6'h00, event_irq});
                i_host_bus_model.rd(8'h19 + 8'(c * 32), d);
                chk("flag", 8'h01 << b, d);
                i_host_bus_model.rd(8'h19 + 8'(c * 32), d);
                chk("clear", 8'h00, d);
                chk("irq_off", 8'h00, {6'h00, event_irq});
            end
        end
        // An event in the very cycle of the clearing read must survive.
        event_pulse[4] = 1'b1;
        fork
            i_host_bus_model.rd(8'h19, d);
            begin
                @(posedge ref_clk);
                #1 event_pulse = '0;
            end
        join
        chk("race", 8'h00, d);
        i_host_bus_model.rd(8'h19, d);
        chk("kept", 8'h10, d);
        // 300 ticks on the first channel, then a clear.
        error_tick[0] = 1'b1;
        repeat (300) @(posedge ref_clk);
        #1 error_tick[0] = 1'b0;
        i_host_bus_model.rd(8'h1A, d);
        chk("cnt_low", 8'h2C, d);
        i_host_bus_model.rd(8'h1B, d);
        chk("cnt_high", 8'h01, d);
        counter_clear[0] = 1'b1;
        @(posedge ref_clk);
        #1 counter_clear[0] = 1'b0;
        i_host_bus_model.rd(8'h1A, d);
        chk("cnt_clr", 8'h00, d);
        // Second channel to full scale, then one tick more wraps it.
        error_tick[1] = 1'b1;
        repeat (65535) @(posedge ref_clk);
        #1 error_tick[1] = 1'b0;
        i_host_bus_model.rd(8'h3B, d);
        chk("cnt_full", 8'hFF, d);
        i_host_bus_model.rd(8'h39, d);
        chk("no_wrap", 8'h00, d);
        error_tick[1] = 1'b1;
        @(posedge ref_clk);
        #1 error_tick[1] = 1'b0;
        i_host_bus_model.rd(8'h39, d);
        chk("wrap", 8'h01, d);
        i_host_bus_model.rd(8'h3A, d);
        chk("wrap_low", 8'h00, d);
        // All strap codes against every termination setting; the line mode follows the strap code.
        for (int m = 0; m < 4; m++) begin
            for (int t = 0; t < 4; t++) begin
                iface = 2'(m);
                term = 2'(t);
                e1 = 2'(m);
                @(posedge ref_clk);
                #1;
                chk("if_mode", 8'(m), {6'h00, mode});
                chk("rx_match", 8'(t), {6'h00, rxm});
                chk("tx_match", 8'(t & m), {6'h00, txm});
            end
        end
        report_and_stop();
    end
endmodule : tb_liu_event_status_counter_regs
`default_nettype wire
